// ==== rtl/smc_pkg.sv ====
/*
 * smc_pkg: constants, register map and carrier types for the serial
 * modem-control pin block.
 * Assumes: a 32-bit APB slave with byte addresses in an 8-bit paddr.
 */
package smc_pkg;

   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int          ADDR_W     = 8;
   localparam int          DATA_W     = 32;
   localparam int          MCR_W      = 8;
   localparam int          LINE_W     = 4;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0]  OFF_MCR    = 8'h00;   // modem_control_register
   localparam logic [7:0]  OFF_MSR    = 8'h04;   // modem_status_register
   localparam logic [7:0]  OFF_EVT    = 8'h08;   // sticky event status, read only
   localparam logic [7:0]  OFF_CLR    = 8'h0c;   // event clear, write only
   localparam logic [7:0]  OFF_ENA    = 8'h10;   // event interrupt enable
   localparam logic [7:0]  OFF_STRAP  = 8'h14;   // strap values, read only

   // ************************************************************
   // reset values and field positions
   // ************************************************************
   localparam logic [MCR_W-1:0]  MCR_RESET   = 8'h00;
   localparam logic [LINE_W-1:0] LINE_RESET  = 4'h0;
   localparam logic [LINE_W-1:0] EVT_RESET   = 4'h0;
   localparam logic [LINE_W-1:0] ENA_RESET   = 4'h0;
   localparam logic [1:0]        STRAP_RESET = 2'h0;
   localparam int                MSR_LINE_LSB = 4;   // live line states in MODEM_STATUS_REGISTER
   localparam int                STRAP_ON_BIT = 2;   // drivers-enabled flag

   // synchroniser lanes: idle pins high, host-bus reset held asserted
   localparam int          SYNC_W     = 7;
   localparam logic [6:0]  SYNC_RESET = 7'h3f;
   localparam int          LN_CTS     = 0;
   localparam int          LN_DSR     = 1;
   localparam int          LN_RI      = 2;
   localparam int          LN_DCD     = 3;
   localparam int          LN_DTR_IN  = 4;
   localparam int          LN_RTS_IN  = 5;
   localparam int          LN_LRESET  = 6;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic [1:0] spare;
      logic       brk;    // force serial_data_out to space outside loopback
      logic       loop;   // loopback mode
      logic       out2;
      logic       out1;
      logic       rts;
      logic       dtr;
   } smc_mcr_type;

   // active-high modem line states; also the event layout
   typedef struct packed {
      logic dcd;
      logic ri;
      logic dsr;
      logic cts;
   } smc_lines_type;

endpackage : smc_pkg

// ==== rtl/smc_sync.sv ====
/*
 * smc_sync: three-stage input synchroniser with agreement filter.
 * Assumes: inputs asynchronous to core_clk; srst synchronous active high.
 */
`timescale 1ns/1ps
module smc_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] stable
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] stable_reg;
   logic [W-1:0] stable_next;

   // a lane changes only once stages two and three agree
   always_comb begin
      stable_next = stable_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            stable_next[i] = s3_reg[i];
         end
      end
   end

   // s1 feeds s2 only, to keep metastability out of the filter
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s1_reg     <= RST_VAL;
         s2_reg     <= RST_VAL;
         s3_reg     <= RST_VAL;
         stable_reg <= RST_VAL;
      end else begin
         s1_reg     <= raw;
         s2_reg     <= s1_reg;
         s3_reg     <= s2_reg;
         stable_reg <= stable_next;
      end
   end

   assign stable = stable_reg;

endmodule : smc_sync

// ==== rtl/smc_modem_pins.sv ====
/*
 * smc_modem_pins: modem control and status pin logic of serial port one,
 * with strap capture on the shared terminal-ready and request-to-send pins.
 * Assumes: APB master on core_clk (25 MHz); modem pins and lreset_n are
 * asynchronous; pad logic merges the _o / _oe_n / _i triples onto pins.
 */
// Implementation choices: the APB interface to the registers and the address map.
// Functional notes
// RULE_01 - low carrier detect reads as carrier present
// RULE_02 - low ring indicator reads as ring received
// RULE_03 - low clear-to-send reads as modem accepting data
// RULE_04 - low data-set-ready reads as modem ready
// RULE_05 - control bit set drives terminal-ready low
// RULE_06 - terminal-ready inactive after reset and in loopback
// RULE_07 - control bit set drives request-to-send low
// RULE_08 - request-to-send inactive after reset and in loopback
// RULE_09 - terminal-ready pin input during host reset, strap a
// RULE_10 - request-to-send pin input during host reset, strap b
// RULE_11 - serial data output marks high after reset
// RULE_12 - latch straps at host reset release, then drive
`timescale 1ns/1ps
module smc_modem_pins
   import smc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              srst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // modem status inputs
   input  wire logic              carrier_detect_n,
   input  wire logic              ring_indicator_n,
   input  wire logic              clear_to_send_n,
   input  wire logic              data_set_ready_n,
   // shared control / strap pins
   input  wire logic              terminal_ready_n_i,
   output logic                   terminal_ready_n_o,
   output logic                   terminal_ready_n_oe_n,
   input  wire logic              request_to_send_n_i,
   output logic                   request_to_send_n_o,
   output logic                   request_to_send_n_oe_n,
   // host-bus reset and misc
   input  wire logic              lreset_n,
   output logic                   serial_data_out,
   output logic                   strap_option_a,
   output logic                   strap_option_b,
   output logic                   irq
);

   // ************************************************************
   // input synchronisation
   // ************************************************************
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_sync;

   // every external level goes through one shared filter bank
   assign pins_raw = {lreset_n, request_to_send_n_i, terminal_ready_n_i,
                      carrier_detect_n, ring_indicator_n,
                      data_set_ready_n, clear_to_send_n};

   smc_sync #(
      .W       (SYNC_W),
      .RST_VAL (SYNC_RESET)
   ) u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .raw      (pins_raw),
      .stable   (pins_sync)
   );

   // ************************************************************
   // apb decode
   // ************************************************************
   logic setup_ph;
   logic wr_acc;
   logic addr_ok;

   // zero wait states: every access completes in its first access cycle
   assign pready   = 1'b1;
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite;

   always_comb begin
      case (paddr)
         OFF_MCR, OFF_MSR, OFF_EVT, OFF_CLR, OFF_ENA, OFF_STRAP: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // ************************************************************
   // control, enable and event state
   // ************************************************************
   smc_mcr_type                mcr_reg;
   smc_mcr_type                mcr_next;
   logic       [LINE_W-1:0]    ena_reg;
   logic       [LINE_W-1:0]    ena_next;
   logic       [LINE_W-1:0]    evt_reg;
   logic       [LINE_W-1:0]    evt_next;
   smc_lines_type              lines_reg;
   smc_lines_type              lines_now;
   smc_lines_type              lines_evt;
   logic       [LINE_W-1:0]    clr_mask;
   logic                       irq_reg;
   logic                       irq_next;

   // live line states; loopback feeds the control bits back instead
   always_comb begin
      if (mcr_reg.loop) begin
         lines_now.cts = mcr_reg.rts;
         lines_now.dsr = mcr_reg.dtr;
         lines_now.ri  = mcr_reg.out1;
         lines_now.dcd = mcr_reg.out2;
      end else begin
         lines_now.cts = ~pins_sync[LN_CTS];            // [RULE_03]
         lines_now.dsr = ~pins_sync[LN_DSR];            // [RULE_04]
         lines_now.ri  = ~pins_sync[LN_RI];             // [RULE_02]
         lines_now.dcd = ~pins_sync[LN_DCD];            // [RULE_01]
      end
   end

   // change events; ring counts only on its trailing edge
   always_comb begin
      lines_evt.cts = lines_now.cts ^ lines_reg.cts;
      lines_evt.dsr = lines_now.dsr ^ lines_reg.dsr;
      lines_evt.ri  = lines_reg.ri & ~lines_now.ri;
      lines_evt.dcd = lines_now.dcd ^ lines_reg.dcd;
   end

   // register writes; a new event beats a clear in the same cycle
   always_comb begin
      mcr_next = mcr_reg;
      ena_next = ena_reg;
      clr_mask = '0;
      if (wr_acc) begin
         case (paddr)
            OFF_MCR: mcr_next = smc_mcr_type'(pwdata[MCR_W-1:0]);
            OFF_ENA: ena_next = pwdata[LINE_W-1:0];
            OFF_CLR: clr_mask = pwdata[LINE_W-1:0];
            default: mcr_next = mcr_reg;
         endcase
      end
      evt_next = (evt_reg & ~clr_mask) | lines_evt;
      irq_next = |(evt_reg & ena_reg);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mcr_reg   <= smc_mcr_type'(MCR_RESET);
         ena_reg   <= ENA_RESET;
         evt_reg   <= EVT_RESET;
         lines_reg <= smc_lines_type'(LINE_RESET);
         irq_reg   <= 1'b0;
      end else begin
         mcr_reg   <= mcr_next;
         ena_reg   <= ena_next;
         evt_reg   <= evt_next;
         lines_reg <= lines_now;
         irq_reg   <= irq_next;
      end
   end

   assign irq = irq_reg;

   // ************************************************************
   // strap capture and shared pin drivers
   // ************************************************************
   logic [1:0] strap_reg;
   logic [1:0] strap_next;
   logic       drv_on_reg;
   logic       drv_on_next;
   logic       host_rst;

   assign host_rst = ~pins_sync[LN_LRESET];

   // sample every cycle of host reset and once more on the release edge:
   // after srst the pin lanes refill together with the host-reset lane, so
   // the last in-reset sample would still hold the filter's reset level;
   // drivers open one edge later, after the value is frozen
   always_comb begin
      strap_next  = strap_reg;
      drv_on_next = ~host_rst;                          // [RULE_12]
      if (host_rst | ~drv_on_reg) begin
         strap_next[0] = pins_sync[LN_DTR_IN];          // [RULE_09]
         strap_next[1] = pins_sync[LN_RTS_IN];          // [RULE_10]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         strap_reg  <= STRAP_RESET;
         drv_on_reg <= 1'b0;
      end else begin
         strap_reg  <= strap_next;
         drv_on_reg <= drv_on_next;
      end
   end

   assign strap_option_a = strap_reg[0];
   assign strap_option_b = strap_reg[1];

   // ************************************************************
   // pin output levels
   // ************************************************************
   logic dtr_o_reg;
   logic dtr_o_next;
   logic rts_o_reg;
   logic rts_o_next;
   logic oe_n_reg;
   logic oe_n_next;
   logic sout_reg;
   logic sout_next;

   // loopback forces the handshake outputs and the data line idle
   always_comb begin
      dtr_o_next = ~(mcr_reg.dtr & ~mcr_reg.loop);      // [RULE_05] [RULE_06]
      rts_o_next = ~(mcr_reg.rts & ~mcr_reg.loop);      // [RULE_07] [RULE_08]
      oe_n_next  = ~drv_on_reg;                         // [RULE_09] [RULE_10]
      sout_next  = ~(mcr_reg.brk & ~mcr_reg.loop);
   end

   // reset leaves both lines inactive, undriven, and the data line marking
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dtr_o_reg <= 1'b1;                             // [RULE_06]
         rts_o_reg <= 1'b1;                             // [RULE_08]
         oe_n_reg  <= 1'b1;
         sout_reg  <= 1'b1;                             // [RULE_11]
      end else begin
         dtr_o_reg <= dtr_o_next;
         rts_o_reg <= rts_o_next;
         oe_n_reg  <= oe_n_next;
         sout_reg  <= sout_next;
      end
   end

   assign terminal_ready_n_o     = dtr_o_reg;
   assign request_to_send_n_o    = rts_o_reg;
   assign terminal_ready_n_oe_n  = oe_n_reg;
   assign request_to_send_n_oe_n = oe_n_reg;
   assign serial_data_out        = sout_reg;

   // ************************************************************
   // read data
   // ************************************************************
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic              err_reg;
   logic              err_next;

   // captured in the setup cycle so prdata comes straight from flops
   always_comb begin
      rdata_next = rdata_reg;
      err_next   = err_reg;
      if (setup_ph) begin
         rdata_next = '0;
         err_next   = ~addr_ok;
         case (paddr)
            OFF_MCR: rdata_next[MCR_W-1:0] = mcr_reg;
            OFF_MSR: begin
               rdata_next[LINE_W-1:0] = evt_reg;
               rdata_next[MSR_LINE_LSB +: LINE_W] = lines_now;   // [RULE_01] [RULE_02]
            end
            OFF_EVT: rdata_next[LINE_W-1:0] = evt_reg;
            OFF_ENA: rdata_next[LINE_W-1:0] = ena_reg;
            OFF_STRAP: begin
               rdata_next[1:0]          = strap_reg;
               rdata_next[STRAP_ON_BIT] = drv_on_reg;
            end
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_reg <= '0;
         err_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   // only meaningful in the access phase; zero otherwise
   assign prdata  = (psel & penable & ~pwrite) ? rdata_reg : '0;
   assign pslverr = psel & penable & err_reg;

endmodule : smc_modem_pins

// ==== testbench/smc_modem_model.sv ====
/*
 * smc_modem_model: behavioural modem on the handshake lines of port one.
 * Assumes: strap resistors on the shared pins win whenever the block
 * releases them; the bench sets the modem line states.
 */
`timescale 1ns/1ps
module smc_modem_model (
   input  wire logic [3:0] line_on,
   input  wire logic       strap_a_val,
   input  wire logic       strap_b_val,
   input  wire logic       terminal_ready_n_o,
   input  wire logic       terminal_ready_n_oe_n,
   input  wire logic       request_to_send_n_o,
   input  wire logic       request_to_send_n_oe_n,
   output logic            carrier_detect_n,
   output logic            ring_indicator_n,
   output logic            clear_to_send_n,
   output logic            data_set_ready_n,
   output logic            terminal_ready_n_i,
   output logic            request_to_send_n_i
);
   // line_on is dcd, ri, dsr, cts active high; the wire is active low
   assign {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n} = ~line_on;
   // a released pin shows its strap level, never the last driven value
   assign terminal_ready_n_i  = terminal_ready_n_oe_n ? strap_a_val : terminal_ready_n_o;
   assign request_to_send_n_i = request_to_send_n_oe_n ? strap_b_val : request_to_send_n_o;
endmodule : smc_modem_model

// ==== testbench/smc_modem_pins_chk.sv ====
/*
 * smc_modem_pins_chk: timing checks on the modem pin block's ports.
 * Assumes: bound to every smc_modem_pins; one clock domain, srst sync.
 */
`timescale 1ns/1ps
module smc_modem_pins_chk
   import smc_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              srst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pslverr,
   input wire logic              carrier_detect_n,
   input wire logic              ring_indicator_n,
   input wire logic              clear_to_send_n,
   input wire logic              data_set_ready_n,
   input wire logic              terminal_ready_n_i,
   input wire logic              terminal_ready_n_o,
   input wire logic              terminal_ready_n_oe_n,
   input wire logic              request_to_send_n_i,
   input wire logic              request_to_send_n_o,
   input wire logic              request_to_send_n_oe_n,
   input wire logic              lreset_n,
   input wire logic              serial_data_out,
   input wire logic              strap_option_a,
   input wire logic              strap_option_b
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   logic loop_reg;
   logic loop_next;
   wire  wr_mcr = psel && penable && pwrite && paddr == OFF_MCR;
   wire  [3:0] pins = {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n};
   // shadow of the loop bit, so forced-idle checks know the mode
   always_comb loop_next = wr_mcr ? pwdata[4] : loop_reg;
   always_ff @(posedge core_clk) loop_reg <= srst ? 1'b0 : loop_next;

   a_dtr_follows_ctl: assert property (wr_mcr && !pwdata[4] |-> ##2
      terminal_ready_n_o == !$past(pwdata[0], 2)) else $error("terminal ready wrong");
   a_rts_follows_ctl: assert property (wr_mcr && !pwdata[4] |-> ##2
      request_to_send_n_o == !$past(pwdata[1], 2)) else $error("request to send wrong");
   a_loop_forces_idle: assert property (loop_reg && $past(loop_reg) |->
      terminal_ready_n_o && request_to_send_n_o) else $error("outputs active in loop");
   a_reset_idle_pins: assert property (disable iff (1'b0) srst |=> terminal_ready_n_o &&
      request_to_send_n_o && serial_data_out && terminal_ready_n_oe_n) else $error("reset idle");
   a_hreset_no_drive: assert property ((!lreset_n)[*8] |->
      terminal_ready_n_oe_n && request_to_send_n_oe_n) else $error("pin driven in host reset");
   a_strap_tracks_pin: assert property ((!lreset_n && $stable(terminal_ready_n_i) &&
      $stable(request_to_send_n_i))[*8] |-> strap_option_a == terminal_ready_n_i &&
      strap_option_b == request_to_send_n_i) else $error("strap does not follow pin");
   a_strap_frozen: assert property (lreset_n[*8] |-> $stable(strap_option_a) &&
      $stable(strap_option_b)) else $error("strap moved after host reset");
   a_drive_after_hrst: assert property (lreset_n[*8] |-> !terminal_ready_n_oe_n &&
      !request_to_send_n_oe_n) else $error("drivers still off");
   a_status_live: assert property ((!loop_reg && $stable(pins))[*8] ##0 (psel && !penable &&
      !pwrite && paddr == OFF_MSR) |=> prdata[7:4] == ~pins) else $error("live status wrong");
   a_unmapped_error: assert property (psel && penable && paddr > OFF_STRAP |->
      pslverr && prdata == '0) else $error("unmapped access not refused");

   c_loop_mode: cover property (loop_reg);
   c_hreset_release: cover property ($rose(lreset_n));
   c_unmapped: cover property (psel && penable && pslverr);
endmodule : smc_modem_pins_chk

bind smc_modem_pins smc_modem_pins_chk chk_u (.*);

// ==== testbench/testbench.sv ====
/*
 * testbench: directed checks of the modem pin block over APB.
 * Assumes: smc_modem_model on the far side; pready answers each access.
 */
`timescale 1ns/1ps
module testbench;
   import smc_pkg::*;
   logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic lreset_n = 1'b0, strap_a_val = 1'b0, strap_b_val = 1'b1, er;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, rd, prdata;
   logic [3:0] line_on = '0;
   logic pready, pslverr, carrier_detect_n, ring_indicator_n, clear_to_send_n, data_set_ready_n;
   logic terminal_ready_n_i, terminal_ready_n_o, terminal_ready_n_oe_n, request_to_send_n_i;
   logic request_to_send_n_o, request_to_send_n_oe_n, serial_data_out;
   logic strap_option_a, strap_option_b, irq;
   int   n_errors = 0, tests_run = 0;
   wire  [7:0] pin_vec = {terminal_ready_n_o, request_to_send_n_o, terminal_ready_n_oe_n,
      request_to_send_n_oe_n, serial_data_out, strap_option_a, strap_option_b, irq};

   smc_modem_pins  dut_u (.*);
   smc_modem_model modem_u (.*);

   // ********************************
   // clock, timeout, shared tasks
   // ********************************
   initial forever #20 core_clk = ~core_clk;
   // whole run is near 220 cycles; a hang ends here
   initial begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      print_verdict();
   end
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask : chk_word
   // pins are sampled mid-cycle, clear of the edge's updates
   task automatic chk_pins(input int n, input logic [7:0] exp);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
      tests_run++;
      if (pin_vec !== exp) begin
         n_errors++;
         $display("mismatch at %0t: pins %b, expected %b", $time, pin_vec, exp);
      end
   endtask : chk_pins
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb

   // ********************************
   // scenarios
   // ********************************
   task automatic t_hreset();
      chk_pins(10, 8'hfa);
      // straps move while host reset still holds: both must follow
      @(posedge core_clk);
      {strap_a_val, strap_b_val} <= 2'b10;
      chk_pins(10, 8'hfc);
      @(posedge core_clk);
      lreset_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      {strap_a_val, strap_b_val} <= 2'b01;
      chk_pins(10, 8'hcc);
      apb(1'b0, OFF_STRAP, '0);
      chk_word(rd, 32'h5);
   endtask : t_hreset
   task automatic t_ctl();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFF_MCR, i);
         chk_pins(3, {~i[0], ~i[1], 6'b001100});
      end
      apb(1'b1, OFF_MCR, 32'h20);
      chk_pins(3, 8'hc4);
   endtask : t_ctl
   // loop mode with both control bits set keeps pins idle
   task automatic t_loop();
      apb(1'b1, OFF_MCR, 32'h13);
      chk_pins(3, 8'hcc);
      apb(1'b0, OFF_MSR, '0);
      chk_word(rd & 32'hf0, 32'h30);
      // out1/out2 loop back as ring and carrier; break is ignored in loop
      apb(1'b1, OFF_MCR, 32'h3c);
      chk_pins(3, 8'hcc);
      apb(1'b0, OFF_MSR, '0);
      chk_word(rd & 32'hf0, 32'hc0);
      apb(1'b1, OFF_MCR, 32'h0);
   endtask : t_loop
   task automatic t_status();
      for (int i = 0; i < 4; i++) begin
         line_on <= 4'h1 << i;
         repeat (8) @(posedge core_clk);
         apb(1'b0, OFF_MSR, '0);
         chk_word(rd & 32'hf0, 32'h10 << i);
      end
      line_on <= 4'h0;
      repeat (8) @(posedge core_clk);
   endtask : t_status
   // raise, mask, unmask and clear the clear-to-send event
   task automatic t_irq();
      apb(1'b1, OFF_CLR, 32'hf);
      apb(1'b0, OFF_EVT, '0);
      chk_word(rd, 32'h0);
      apb(1'b1, OFF_ENA, 32'h1);
      line_on <= 4'h1;
      chk_pins(8, 8'hcd);
      apb(1'b0, OFF_EVT, '0);
      chk_word(rd, 32'h1);
      apb(1'b1, OFF_ENA, 32'h0);
      chk_pins(3, 8'hcc);
      apb(1'b1, OFF_ENA, 32'h1);
      chk_pins(3, 8'hcd);
      apb(1'b1, OFF_CLR, 32'h1);
      chk_pins(3, 8'hcc);
   endtask : t_irq
   task automatic t_bus();
      apb(1'b0, 8'h18, '0);
      chk_word({rd[30:0], er}, 32'h1);
      apb(1'b0, OFF_CLR, '0);
      chk_word({rd[30:0], er}, 32'h0);
   endtask : t_bus
   // second reset in mid-run with control bits active
   task automatic t_srst();
      apb(1'b1, OFF_MCR, 32'h3);
      chk_pins(3, 8'h0c);
      @(posedge core_clk);
      srst <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      chk_pins(0, 8'hf8);
      apb(1'b0, OFF_MCR, '0);
      chk_word(rd, 32'h0);
      // straps relatch from the released pins, not the filter's reset level
      chk_pins(10, 8'hca);
   endtask : t_srst

   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      t_hreset();
      t_ctl();
      t_loop();
      t_status();
      t_irq();
      t_bus();
      t_srst();
      print_verdict();
   end
endmodule : testbench
